// ==== sim/sled_checker_assertions.sv ====
// Assertion checker for the status indicator controller
`timescale 1ns/10ps
`default_nettype none
module sled_checker
#(parameter int FLASH_ON_CYC = 5)
(
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic [15:0] host_addr,
	input wire logic        host_rd,
	input wire logic [7:0]  host_data,
	input wire logic        host_data_oe_n,
	input wire logic [7:0]  rom_data,
	input wire logic        card_busy,
	input wire logic        led_red,
	input wire logic        led_green
);
	int   run;
	logic done;
	logic rom;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	assign rom = host_addr >= 16'hc000 && host_addr <= 16'hfec8;
	// Green held past one flash marks the host-controlled phase
	always_ff @(posedge clk_sys)
	begin
		run <= (rst || !led_green) ? 0 : (run > FLASH_ON_CYC ? run : run + 1);
		done <= !rst && (done || run > FLASH_ON_CYC);
	end
	red_lag_a: assert property (led_red == $past(card_busy))
		else $error("red lag");
	flash_len_a: assert property (!done && $fell(led_green) |-> run == FLASH_ON_CYC)
		else $error("flash");
	green_off_a:
		assert property (done && $rose(host_rd) && host_addr == 16'hfed6 |=> !led_green)
		else $error("off");
	green_on_a:
		assert property (done && $rose(host_rd) && host_addr == 16'hfed7 |=> led_green)
		else $error("on");
	rom_oe_a: assert property ($rose(host_rd) && rom |=> !host_data_oe_n)
		else $error("oe");
	rom_byte_a: assert property (host_rd && rom |=> host_data == $past(rom_data))
		else $error("byte");
	bus_idle_a: assert property (!host_rd |=> host_data_oe_n)
		else $error("idle");
	no_drive_a: assert property (host_rd && !rom |=> host_data_oe_n && host_data == 8'h00)
		else $error("drive");
endmodule
bind sled_top sled_checker #(.FLASH_ON_CYC(FLASH_ON_CYC)) u_chk (
	.clk_sys        (clk_sys),
	.rst            (rst),
	.host_addr      (host_addr),
	.host_rd        (host_rd),
	.host_data      (host_data),
	.host_data_oe_n (host_data_oe_n),
	.rom_data       (rom_data),
	.card_busy      (card_busy),
	.led_red        (led_red),
	.led_green      (led_green)
);
`default_nettype wire

// ==== sim/sled_host.sv ====
// Host processor model issuing byte reads on the card bus
`timescale 1ns/10ps
`default_nettype none
module sled_host
(
	input  wire logic        clk_sys,
	output var  logic [15:0] host_addr = 16'h0000,
	output var  logic        host_rd = 1'b0
);
	// Strobe and address held across the answer edge, then released
	task automatic rd(input logic [15:0] a);
		@(posedge clk_sys);
		#1 host_addr = a;
		host_rd = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 host_rd = 1'b0;
		host_addr = ~a;
	endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Testbench for the status indicator controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        clk_sys, rst, card_busy, card_host_access;
	logic        mouse_detect_valid, mouse_has_wheel;
	logic        host_rd, host_data_oe_n, led_red, led_green;
	logic [15:0] host_addr;
	logic [13:0] rom_addr;
	logic [7:0]  host_data, rom_data;
	int          n_fail = 0, num_checks = 0;
	assign rom_data = rom_addr[7:0] ^ rom_addr[13:6];
	sled_host u_host (
		.clk_sys   (clk_sys),
		.host_addr (host_addr),
		.host_rd   (host_rd)
	);
	sled_top #(
		.FLASH_ON_CYC  (5),
		.FLASH_OFF_CYC (5)
	) u_dut (
		.clk_sys            (clk_sys),
		.rst                (rst),
		.host_addr          (host_addr),
		.host_rd            (host_rd),
		.host_data          (host_data),
		.host_data_oe_n     (host_data_oe_n),
		.rom_addr           (rom_addr),
		.rom_data           (rom_data),
		.card_busy          (card_busy),
		.card_host_access   (card_host_access),
		.mouse_detect_valid (mouse_detect_valid),
		.mouse_has_wheel    (mouse_has_wheel),
		.led_red            (led_red),
		.led_green          (led_green)
	);
	initial
	begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic do_reset;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		chk({led_red, led_green, host_data_oe_n, host_data}, 16'h0100);
	endtask
	task automatic t_red;
		card_busy = 1'b1;
		tick(3);
		chk(led_red, 1'b1);
		card_busy = 1'b0;
		tick(1);
		chk(led_red, 1'b0);
	endtask
	task automatic t_flash(input logic w, input int n);
		int   k;
		logic p;
		k = 0;
		p = 1'b0;
		mouse_has_wheel = w;
		mouse_detect_valid = 1'b1;
		tick(1);
		mouse_detect_valid = 1'b0;
		repeat (30)
		begin
			tick(1);
			k += int'(led_green && !p);
			p = led_green;
		end
		chk(16'(k), 16'(n));
	endtask
	task automatic t_green;
		u_host.rd(16'hfed7);
		chk(led_green, 1'b0);
		card_host_access = 1'b1;
		tick(1);
		card_host_access = 1'b0;
		tick(10);
		chk(led_green, 1'b1);
		u_host.rd(16'hfed6);
		chk({led_green, host_data_oe_n}, 2'b01);
		u_host.rd(16'hfed6);
		chk(led_green, 1'b0);
		u_host.rd(16'hfed7);
		chk({led_green, led_red}, 2'b10);
	endtask
	task automatic t_rom;
		logic [15:0] a [4] = '{16'hc000, 16'hfec8, 16'hfec9, 16'hbfff};
		foreach (a[i])
		begin
			u_host.rd(a[i]);
			chk(host_data_oe_n, 16'(i > 1));
			chk(host_data, i > 1 ? 8'h00 : a[i][7:0] ^ a[i][13:6]);
		end
	endtask
	task automatic t_no_mouse;
		card_host_access = 1'b1;
		tick(1);
		card_host_access = 1'b0;
		tick(1);
		chk(led_green, 1'b1);
	endtask
	initial
	begin
		card_busy = 1'b0;
		card_host_access = 1'b0;
		mouse_detect_valid = 1'b0;
		mouse_has_wheel = 1'b0;
		do_reset;
		t_red;
		t_flash(1'b0, 1);
		t_green;
		t_rom;
		do_reset;
		t_flash(1'b1, 2);
		do_reset;
		t_no_mouse;
		report_and_stop;
	end
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop;
	end
endmodule
`default_nettype wire

// ==== verilog/sled_bus_if.sv ====
// Interface carrying decoded host strobes to the indicator controller
`timescale 1ns/10ps
`default_nettype none
interface sled_bus_if;
	logic rd_strobe;
	logic green_off;
	logic green_on;
	logic rom_sel;
	logic claim;
	modport decoder (output rd_strobe, output green_off, output green_on,
		output rom_sel, output claim);
	modport ctrl (input rd_strobe, input green_off, input green_on,
		input rom_sel, input claim);
endinterface
`default_nettype wire

// ==== verilog/sled_decode.sv ====
// Host address decoder for the card's claimed window
`timescale 1ns/10ps
`default_nettype none
module sled_decode
	import sled_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] host_addr,
	input  wire logic        host_rd,
	sled_bus_if.decoder      bus
);
	typedef struct packed {
		logic rd;
	} sled_dec_state_type;
	sled_dec_state_type state;
	sled_dec_state_type next_state;
	logic in_claim;

	always_comb
	begin
		next_state = state;
		next_state.rd = host_rd;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
			state <= '0;
		else
			state <= next_state;
	end

	assign in_claim = host_addr >= SLED_CLAIM_BASE;
	assign bus.claim = in_claim;
	assign bus.rom_sel = host_rd && host_addr >= SLED_ROM_BASE && host_addr <= SLED_ROM_LAST;
	// One pulse per read, at its start
	assign bus.rd_strobe = host_rd && !state.rd;
	assign bus.green_off = bus.rd_strobe && host_addr == SLED_ADDR_GREEN_OFF;
	assign bus.green_on = bus.rd_strobe && host_addr == SLED_ADDR_GREEN_ON;
endmodule
`default_nettype wire

// ==== verilog/sled_pkg.sv ====
// Package with constants for the status indicator controller
package sled_pkg;
	localparam logic [15:0] SLED_ADDR_GREEN_OFF = 16'hfed6;
	localparam logic [15:0] SLED_ADDR_GREEN_ON  = 16'hfed7;
	localparam logic [15:0] SLED_CLAIM_BASE     = 16'hc000;
	localparam logic [15:0] SLED_CLAIM_LAST     = 16'hffff;
	localparam logic [15:0] SLED_ROM_BASE       = 16'hc000;
	localparam logic [15:0] SLED_ROM_LAST       = 16'hfec8;
	localparam int SLED_ROM_BYTES = 16384;
	localparam int SLED_CLK_HZ = 10000000;
	localparam int SLED_FLASH_ON_MS = 200;
	localparam int SLED_FLASH_OFF_MS = 200;
	localparam int SLED_FLASH_ON_CYC = SLED_CLK_HZ / 1000 * SLED_FLASH_ON_MS;
	localparam int SLED_FLASH_OFF_CYC = SLED_CLK_HZ / 1000 * SLED_FLASH_OFF_MS;
	localparam logic [1:0] SLED_FLASH_NONE = 2'h0;
	localparam logic [1:0] SLED_FLASH_ONE  = 2'h1;
	localparam logic [1:0] SLED_FLASH_TWO  = 2'h2;
	localparam logic [1:0] SLED_RESET_FLASHES = 2'h0;
	localparam logic SLED_RESET_GREEN = 1'b0;
endpackage

// ==== verilog/sled_top.sv ====
// Status indicator controller: red activity, green flashes and host control
// Summary of operation
// - Red lights while a memory-card transfer is in progress, dark otherwise.
// - Standard mouse detected at power-up gives exactly one green flash.
// - Wheel mouse detected at power-up gives two green flashes.
// - First host card access turns green on steadily.
// - Byte read of address 65238 switches green off, only after the first card access and the power-up flashes.
// - Byte read of 65239 switches green on, only after the first card access and the power-up flashes.
// - A 16073-byte read-only region C000 to FEC8 holds driver code.
// - 8-bit data, 16-bit address; card claims C000 to FFFF.
`timescale 1ns/10ps
`default_nettype none
module sled_top
	import sled_pkg::*;
#(
	parameter int FLASH_ON_CYC  = SLED_FLASH_ON_CYC,
	parameter int FLASH_OFF_CYC = SLED_FLASH_OFF_CYC
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [15:0] host_addr,
	input  wire logic        host_rd,
	output logic      [7:0]  host_data,
	output logic             host_data_oe_n,
	output logic      [13:0] rom_addr,
	input  wire logic [7:0]  rom_data,
	input  wire logic        card_busy,
	input  wire logic        card_host_access,
	input  wire logic        mouse_detect_valid,
	input  wire logic        mouse_has_wheel,
	output logic             led_red,
	output logic             led_green
);
	typedef enum logic [3:0] {
		ST_WAIT   = 4'b0001,
		ST_ON     = 4'b0010,
		ST_OFF    = 4'b0100,
		ST_DONE   = 4'b1000
	} sled_phase_type;

	typedef struct packed {
		sled_phase_type phase;
		logic [1:0]     flashes;
		logic [31:0]    count;
		logic           green;
		logic           red;
		logic           accessed;
		logic [7:0]     data;
		logic           oe_n;
		logic           lamp;
	} sled_state_type;

	sled_state_type state;
	sled_state_type next_state;
	sled_bus_if     bus();
	logic [31:0]    on_cycles;
	logic [31:0]    off_cycles;
	logic           timer_end;
	logic [1:0]     detect_flashes;
	logic           ctrl_read;

	sled_decode u_decode (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.host_addr (host_addr),
		.host_rd   (host_rd),
		.bus       (bus)
	);

	assign rom_addr = host_addr[13:0];

	// Period lengths widened once to the counter's width
	assign on_cycles = 32'(FLASH_ON_CYC);
	assign off_cycles = 32'(FLASH_OFF_CYC);
	// Current lit or dark period runs out this cycle
	assign timer_end = state.count <= 32'h1;
	assign detect_flashes = mouse_has_wheel ? SLED_FLASH_TWO : SLED_FLASH_ONE;
	// Host control only once the card has been touched
	assign ctrl_read = state.accessed && bus.rd_strobe && bus.claim;

	always_comb
	begin
		next_state = state;
		next_state.red = card_busy;
		// Data returned only inside the ROM window
		if (bus.rom_sel && bus.claim)
		begin
			next_state.data = rom_data;
			next_state.oe_n = 1'b0;
		end
		else
		begin
			next_state.data = 8'h00;
			next_state.oe_n = 1'b1;
		end
		case (state.phase)
			ST_WAIT:
			begin
				// Mouse report starts the flashes; a card access skips them
				if (mouse_detect_valid)
				begin
					next_state.flashes = detect_flashes;
					next_state.count = on_cycles;
					next_state.phase = ST_ON;
				end
				else if (card_host_access)
				begin
					next_state.phase = ST_DONE;
				end
			end
			ST_ON:
			begin
				if (timer_end)
				begin
					next_state.flashes = state.flashes - 2'h1;
					next_state.count = off_cycles;
					next_state.phase = ST_OFF;
				end
				else
				begin
					next_state.count = state.count - 32'h1;
				end
			end
			ST_OFF:
			begin
				if (timer_end)
				begin
					if (state.flashes != SLED_FLASH_NONE)
					begin
						next_state.count = on_cycles;
						next_state.phase = ST_ON;
					end
					else
					begin
						next_state.phase = ST_DONE;
					end
				end
				else
				begin
					next_state.count = state.count - 32'h1;
				end
			end
			ST_DONE:
			begin
				if (card_host_access && !state.accessed)
				begin
					next_state.accessed = 1'b1;
					next_state.green = 1'b1;
				end
				else if (ctrl_read)
				begin
					case ({bus.green_on, bus.green_off})
						2'b01:
						begin
							next_state.green = 1'b0;
						end
						2'b10:
						begin
							next_state.green = 1'b1;
						end
						default:
						begin
							next_state.green = state.green;
						end
					endcase
				end
			end
			default:
			begin
				next_state.phase = ST_WAIT;
				next_state.flashes = SLED_FLASH_NONE;
				next_state.count = 32'h0;
			end
		endcase
		// Host may touch the card during flashes; remember it
		if (state.phase != ST_DONE && card_host_access)
		begin
			next_state.accessed = 1'b1;
			next_state.green = 1'b1;
		end
		// Flash pattern overrides green until it ends
		case (next_state.phase)
			ST_ON:
			begin
				next_state.lamp = 1'b1;
			end
			ST_DONE:
			begin
				next_state.lamp = next_state.green;
			end
			default:
			begin
				next_state.lamp = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			state.phase <= ST_WAIT;
			state.flashes <= SLED_RESET_FLASHES;
			state.count <= 32'h0;
			state.green <= SLED_RESET_GREEN;
			state.red <= 1'b0;
			state.accessed <= 1'b0;
			state.data <= 8'h00;
			state.oe_n <= 1'b1;
			state.lamp <= 1'b0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign host_data = state.data;
	assign host_data_oe_n = state.oe_n;
	assign led_red = state.red;
	assign led_green = state.lamp;
endmodule
`default_nettype wire
